// ==== hdl/vent_relay_pkg.sv ====
package vent_relay_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PER_TICK = 1;
  localparam int MS_CYC_DEF = MS_PER_TICK * 1_000_000 / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int S_PER_H = 3600;
  // Timing figures as specified
  localparam int PAUSE_MS = 500;
  localparam int DM_HOLD_MS = 3000;
  localparam int RT_TRIES = 15;
  localparam int RT_CLOSE_S = 3;
  localparam int RT_IVL_MIN = 2;
  localparam int RT_MAX_MIN = 30;
  localparam int EMG_KEEP_MIN = 3;
  localparam int ECO_MIN = 3;
  localparam int ACLS_MAX_H = 24;
  localparam int TW_MIN_S = 10;
  localparam int TW_MAX_H = 12;
  // Derived counts
  localparam int RT_CLOSE_MS = RT_CLOSE_S * MS_PER_S;
  localparam int RT_IVL_S = RT_IVL_MIN * S_PER_MIN;
  localparam int RT_MAX_S = RT_MAX_MIN * S_PER_MIN;
  localparam int EMG_S = EMG_KEEP_MIN * S_PER_MIN;
  localparam int ECO_S = ECO_MIN * S_PER_MIN;
  localparam int ACLS_MAX_S = ACLS_MAX_H * S_PER_H;
  localparam int TW_MAX_S = TW_MAX_H * S_PER_H;
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PRIO = 8'h04;
  localparam logic [7:0] REG_GRP0 = 8'h08;
  localparam logic [7:0] REG_GRP1 = 8'h0c;
  localparam logic [7:0] REG_GRP2 = 8'h10;
  localparam logic [7:0] REG_ADLY = 8'h14;
  localparam logic [7:0] REG_VDLY = 8'h18;
  localparam logic [7:0] REG_GAP = 8'h1c;
  localparam logic [7:0] REG_ACLS = 8'h20;
  localparam logic [7:0] REG_TWAIT = 8'h24;
  localparam logic [7:0] REG_BMODE = 8'h28;
  localparam logic [7:0] REG_STAT = 8'h2c;
  // Fields and reset values
  localparam int PRIO_INV_LSB = 6;
  localparam int ACLS_UNIT_LSB = 16;
  localparam logic [1:0] UNIT_S = 2'h0;
  localparam logic [1:0] UNIT_MIN = 2'h1;
  localparam logic [1:0] UNIT_H = 2'h2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [8:0] PRIO_RST = 9'h024;
  localparam logic [15:0] TWAIT_RST = 16'h000a;
  localparam logic [11:0] BMODE_RST = 12'h000;

  typedef enum logic [1:0] {
    DIR_OFF = 2'b00, DIR_OPEN = 2'b01, DIR_CLOSE = 2'b10
  } dir_t;
  typedef enum logic [2:0] {
    BM_AUTO_DM_TS = 3'b000, BM_AUTO_DM = 3'b001, BM_NO_DM_TS = 3'b010,
    BM_NO_DM = 3'b011, BM_DM_ONLY = 3'b100
  } btn_mode_t;
  typedef enum logic [1:0] {
    RT_IDLE = 2'b00, RT_RUN = 2'b01, RT_SHUT = 2'b10, RT_HOLD = 2'b11
  } rt_state_t;
  typedef struct packed {
    logic thermo_en;
    logic eco_en;
    logic autoclose_en;
    logic gap_en;
    logic wind_en;
    logic dep_en;
    logic ext_prio;
    logic retrig_en;
  } ctrl_t;
endpackage : vent_relay_pkg

// ==== hdl/smoke_vent_motor_relay_control.sv ====
// Behaviour
// - OPEN puts plus on S pole; CLOSE reverses polarity.
// - Emergency power releases load relays; an alarm energises them again.
// - Alarm shows at once; actuators move only after alarm start delay.
// - Three priority lines by default; triggered assigned sensor opens actuators.
// - Any priority order; each line may be inverted to drive CLOSE.
// - Basic mode shares one sensor group; extended mode has one per level.
// - Deadlock retrigger makes fifteen OPEN actuations after an alarm.
// - Each retry starts with 3 s CLOSE, retries every 2 minutes.
// - 500 ms unpowered pause on every change of direction.
// - After 30 minutes of retrigger, OPEN stays permanently on.
// - Retrigger off after reset, enabled per module.
// - With dependency on, alarm drives need analog current, else nothing moves.
// - Ventilation commands accepted only in mains operation.
// - Running ventilation command is kept 3 minutes on emergency power.
// - Button held over three seconds becomes dead man drive.
// - Brief press latches drive; tip-stop modes stop on repeat press.
// - Five selectable behaviours per button input and direction.
// - Ventilation shows at once; actuators move after vent start delay.
// - Per-module choice to react to the wind/rain signal.
// - Gap mode limits every vent run, OPEN or CLOSE; OPEN refused while gap CLOSE runs.
// - Automatic close after set wait in s, min or h, max 24 h.
// - Eco mode de-energises outputs 3 minutes after last vent command.
// - Thermostat re-query waits 10 s to 12 h after manual override.
`timescale 1ns/100ps
module smoke_vent_motor_relay_control #(
  parameter int NSI = 4,
  parameter int MS_CYC = vent_relay_pkg::MS_CYC_DEF
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic rst, // Synchronous reset
  input wire logic [vent_relay_pkg::ADDR_W-1:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  input wire logic [2:0][NSI-1:0] sensor_trig, // Alarm per line per sensor module
  input wire logic mains_ok, // Mains present
  input wire logic analog_ok, // Analog loop current present
  input wire logic wind_rain_signal, // Central wind/rain signal
  input wire logic [3:0] vent_button_inputs, // {b2 cls, b2 opn, b1 cls, b1 opn}
  input wire logic thermostat_in, // Thermostat demand, high opens
  output logic pole_s_pos, // S plus, O minus
  output logic pole_o_pos, // O plus, S minus
  output logic load_on, // Load relays energised
  output logic alarm_ind, // Alarm registered
  output logic vent_ind // Ventilation command registered
);
  import vent_relay_pkg::*;

  localparam int XW = 3 * NSI + 8;
  // One-bit floor keeps the ms divider legal when MS_CYC is 1
  localparam int MW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;

  // Input synchronisers
  logic [XW-1:0] x1_r, x2_r;
  logic [2:0][NSI-1:0] s_trig;
  logic s_mains, s_ana, s_wind, s_th;
  logic [3:0] s_btn;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      x1_r <= '0;
      x2_r <= '0;
    end else begin
      x1_r <= {sensor_trig, mains_ok, analog_ok, wind_rain_signal,
               vent_button_inputs, thermostat_in};
      x2_r <= x1_r;
    end
  end
  assign s_trig = x2_r[XW-1:8];
  assign s_mains = x2_r[7];
  assign s_ana = x2_r[6];
  assign s_wind = x2_r[5];
  assign s_btn = x2_r[4:1];
  assign s_th = x2_r[0];

  // Millisecond and second enables
  logic [MW-1:0] ms_cnt_r;
  logic [9:0] s_cnt_r;
  logic ms_tick, s_tick;
  assign ms_tick = ms_cnt_r == MW'(MS_CYC - 1);
  assign s_tick = ms_tick && s_cnt_r == 10'(MS_PER_S - 1);

  always_ff @(posedge ref_clk) begin
    if (rst || ms_tick) ms_cnt_r <= '0;
    else ms_cnt_r <= ms_cnt_r + 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || s_tick) s_cnt_r <= '0;
    else if (ms_tick) s_cnt_r <= s_cnt_r + 1'b1;
  end

  // Registers
  ctrl_t ctrl_r;
  logic [8:0] prio_r;
  logic [2:0][NSI-1:0] grp_r;
  logic [15:0] adly_r, vdly_r, gap_r, twait_r;
  logic [17:0] acls_r;
  logic [3:0][2:0] bmode_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      prio_r <= PRIO_RST;
      grp_r <= '1;
      adly_r <= '0;
      vdly_r <= '0;
      gap_r <= '0;
      acls_r <= '0;
      twait_r <= TWAIT_RST;
      bmode_r <= BMODE_RST;
    end else if (wr_en) begin
      case (addr)
        REG_CTRL: ctrl_r <= wdata[7:0];
        REG_PRIO: prio_r <= wdata[8:0];
        REG_GRP0: grp_r[0] <= wdata[NSI-1:0];
        REG_GRP1: grp_r[1] <= wdata[NSI-1:0];
        REG_GRP2: grp_r[2] <= wdata[NSI-1:0];
        REG_ADLY: adly_r <= wdata[15:0];
        REG_VDLY: vdly_r <= wdata[15:0];
        REG_GAP: gap_r <= wdata[15:0];
        REG_ACLS: acls_r <= wdata[17:0];
        REG_TWAIT: twait_r <= wdata[15:0];
        REG_BMODE: bmode_r <= wdata[11:0];
        default: ;
      endcase
    end
  end

  // Alarm line selection
  logic [2:0] hit;
  logic [1:0] sel;
  logic a_req, a_go;
  dir_t a_dir;

  always_comb begin
    for (int l = 0; l < 3; l++) begin
      hit[l] = |(s_trig[l] & (ctrl_r.ext_prio ? grp_r[l] : grp_r[0]));
    end
    sel = 2'd0;
    a_req = 1'b0;
    for (int k = 2; k >= 0; k--) begin
      if (prio_r[2*k+:2] != 2'd3 && hit[prio_r[2*k+:2]]) begin
        sel = prio_r[2*k+:2];
        a_req = 1'b1;
      end
    end
    a_dir = prio_r[PRIO_INV_LSB + sel] ? DIR_CLOSE : DIR_OPEN;
  end

  // Alarm start delay
  // Own ms count so the delay starts at the alarm, not at a free second
  logic [15:0] ad_r;
  logic [9:0] ad_ms_r;
  logic ad_sec;
  assign ad_sec = ms_tick && ad_ms_r == 10'(MS_PER_S - 1);
  always_ff @(posedge ref_clk) begin
    if (rst || !a_req || ad_sec) ad_ms_r <= '0;
    else if (ms_tick) ad_ms_r <= ad_ms_r + 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !a_req) ad_r <= '0;
    else if (ad_sec && ad_r < adly_r) ad_r <= ad_r + 1'b1;
  end
  assign a_go = a_req && ad_r >= adly_r;

  // Deadlock retrigger sequencer
  rt_state_t rt_st;
  logic [10:0] rt_tot_r;
  logic [6:0] rt_ivl_r;
  logic [3:0] rt_n_r;
  logic [11:0] rt_ms_r;
  logic rt_on;
  dir_t cur_r;
  assign rt_on = a_go && a_dir == DIR_OPEN && ctrl_r.retrig_en;

  always_ff @(posedge ref_clk) begin
    if (rst || !rt_on) begin
      rt_st <= RT_IDLE;
      rt_tot_r <= '0;
      rt_ivl_r <= '0;
      rt_n_r <= '0;
      rt_ms_r <= '0;
    end else begin
      if (s_tick && rt_st != RT_HOLD) rt_tot_r <= rt_tot_r + 1'b1;
      case (rt_st)
        RT_IDLE: begin
          rt_st <= RT_RUN;
          rt_n_r <= 4'd1;
        end
        RT_RUN: begin
          if (s_tick) begin
            rt_ivl_r <= rt_ivl_r + 1'b1;
            if (rt_tot_r >= 11'(RT_MAX_S - 1)) begin
              rt_st <= RT_HOLD;
            end else if (rt_ivl_r == 7'(RT_IVL_S - 1)) begin
              rt_st <= (rt_n_r < 4'(RT_TRIES)) ? RT_SHUT : RT_HOLD;
              rt_ms_r <= '0;
            end
          end
        end
        RT_SHUT: begin
          if (ms_tick && cur_r == DIR_CLOSE) begin
            rt_ms_r <= rt_ms_r + 1'b1;
            if (rt_ms_r == 12'(RT_CLOSE_MS - 1)) begin
              rt_st <= RT_RUN;
              rt_n_r <= rt_n_r + 1'b1;
              rt_ivl_r <= '0;
            end
          end
        end
        RT_HOLD: rt_st <= RT_HOLD;
        default: rt_st <= RT_IDLE;
      endcase
    end
  end

  // Ventilation buttons
  logic vent_on_r;
  dir_t vent_dir_r;
  logic [3:0] b_start, b_stop, p_r;
  logic [3:0][12:0] hc_r;

  for (genvar i = 0; i < 4; i++) begin : g_btn
    btn_mode_t m;
    logic rise, fall, dm_long, auto_dm, tip, tipstop;
    dir_t bdir;
    assign m = btn_mode_t'(bmode_r[i]);
    assign bdir = (i % 2 == 1) ? DIR_CLOSE : DIR_OPEN;
    assign rise = s_btn[i] && !p_r[i];
    assign fall = !s_btn[i] && p_r[i];
    assign dm_long = hc_r[i] > 13'(DM_HOLD_MS);
    assign auto_dm = m == BM_AUTO_DM_TS || m == BM_AUTO_DM;
    assign tip = m == BM_AUTO_DM_TS || m == BM_NO_DM_TS;
    assign tipstop = rise && tip && vent_on_r && vent_dir_r == bdir;
    assign b_start[i] = rise && !tipstop;
    assign b_stop[i] = tipstop || (fall && (m == BM_DM_ONLY || (auto_dm && dm_long)));

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        p_r[i] <= 1'b0;
        hc_r[i] <= '0;
      end else begin
        p_r[i] <= s_btn[i];
        if (!s_btn[i]) hc_r[i] <= '0;
        else if (ms_tick && hc_r[i] <= 13'(DM_HOLD_MS)) hc_r[i] <= hc_r[i] + 1'b1;
      end
    end
  end

  logic man_go, man_stop;
  dir_t man_dir;
  always_comb begin
    man_go = 1'b0;
    man_stop = 1'b0;
    man_dir = DIR_OPEN;
    for (int i = 3; i >= 0; i--) begin
      if (b_stop[i]) begin
        man_stop = 1'b1;
        man_go = 1'b0;
      end else if (b_start[i]) begin
        man_go = 1'b1;
        man_stop = 1'b0;
        man_dir = (i % 2 == 1) ? DIR_CLOSE : DIR_OPEN;
      end
    end
  end

  // Thermostat with re-query lockout
  logic th_p_r, th_evt, wp_r, wind_force, wind_edge;
  logic [15:0] tl_r, tw_cl;
  dir_t th_dir;
  assign tw_cl = (twait_r < 16'(TW_MIN_S)) ? 16'(TW_MIN_S) :
                 (twait_r > 16'(TW_MAX_S)) ? 16'(TW_MAX_S) : twait_r;
  assign th_evt = ctrl_r.thermo_en && s_th != th_p_r && tl_r == '0;
  assign th_dir = s_th ? DIR_OPEN : DIR_CLOSE;
  assign wind_force = ctrl_r.wind_en && s_wind;
  assign wind_edge = wind_force && !wp_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      th_p_r <= 1'b0;
      wp_r <= 1'b0;
      tl_r <= '0;
    end else begin
      th_p_r <= s_th;
      wp_r <= wind_force;
      if (ctrl_r.thermo_en && s_mains && (man_go || man_stop)) tl_r <= tw_cl;
      else if (s_tick && tl_r != '0) tl_r <= tl_r - 1'b1;
    end
  end

  // Ventilation command state
  logic [16:0] v_sec_r;
  logic [7:0] eco_r, emg_r;
  logic [31:0] ac_lim;
  logic ac_hit, gap_stop, gap_lock, v_drv, c_go, c_stop, v_end, v_tick;
  logic [9:0] v_ms_r;
  dir_t c_dir;

  // Command seconds counted from the command itself
  assign v_tick = ms_tick && v_ms_r == 10'(MS_PER_S - 1);
  always_ff @(posedge ref_clk) begin
    if (rst || c_go || v_tick) v_ms_r <= '0;
    else if (ms_tick) v_ms_r <= v_ms_r + 1'b1;
  end

  always_comb begin
    case (acls_r[ACLS_UNIT_LSB+:2])
      UNIT_MIN: ac_lim = {16'h0000, acls_r[15:0]} * S_PER_MIN;
      UNIT_H: ac_lim = {16'h0000, acls_r[15:0]} * S_PER_H;
      default: ac_lim = {16'h0000, acls_r[15:0]};
    endcase
    if (ac_lim > ACLS_MAX_S) ac_lim = ACLS_MAX_S;
  end
  assign ac_hit = ctrl_r.autoclose_en && vent_on_r && vent_dir_r == DIR_OPEN &&
                  {15'h0000, v_sec_r} >= ac_lim;
  assign gap_stop = ctrl_r.gap_en && vent_on_r &&
                    v_sec_r >= {1'b0, vdly_r} + {1'b0, gap_r};
  assign gap_lock = ctrl_r.gap_en && vent_on_r && vent_dir_r == DIR_CLOSE;

  always_comb begin
    c_go = 1'b0;
    c_stop = 1'b0;
    c_dir = DIR_CLOSE;
    if (s_mains) begin
      if (wind_edge) c_go = 1'b1;
      else if (man_stop) c_stop = 1'b1;
      else if (man_go) begin
        c_go = 1'b1;
        c_dir = man_dir;
      end else if (th_evt) begin
        c_go = 1'b1;
        c_dir = th_dir;
      end else if (ac_hit) c_go = 1'b1;
      if (c_dir == DIR_OPEN && (gap_lock || wind_force)) c_go = 1'b0;
    end
  end

  assign v_end = c_stop || gap_stop || (!s_mains && emg_r == 8'(EMG_S)) ||
                 (ctrl_r.eco_en && eco_r == 8'(ECO_S));

  always_ff @(posedge ref_clk) begin
    if (rst || s_mains) emg_r <= '0;
    else if (s_tick && emg_r != 8'(EMG_S)) emg_r <= emg_r + 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vent_on_r <= 1'b0;
      vent_dir_r <= DIR_OPEN;
      v_sec_r <= '0;
      eco_r <= '0;
    end else begin
      if (c_go || c_stop) eco_r <= '0;
      else if (s_tick && eco_r != 8'(ECO_S)) eco_r <= eco_r + 1'b1;
      if (c_go) begin
        vent_on_r <= 1'b1;
        vent_dir_r <= c_dir;
        v_sec_r <= '0;
      end else if (v_end) begin
        vent_on_r <= 1'b0;
      end else if (v_tick && v_sec_r != '1) begin
        v_sec_r <= v_sec_r + 1'b1;
      end
    end
  end
  assign v_drv = vent_on_r && v_sec_r >= {1'b0, vdly_r};

  // Drive selection and direction-change pause
  dir_t des, cur_nxt, last_r;
  logic ld;
  logic [8:0] pz_r;
  assign ld = s_mains || a_go || vent_on_r;

  always_comb begin
    des = DIR_OFF;
    if (a_req) begin
      if (a_go && !(ctrl_r.dep_en && !s_ana)) begin
        des = (rt_st == RT_SHUT) ? DIR_CLOSE : a_dir;
      end
    end else if (v_drv) begin
      des = vent_dir_r;
    end
    if (!ld) des = DIR_OFF;
    cur_nxt = cur_r;
    if (des != cur_r) begin
      if (cur_r != DIR_OFF) cur_nxt = DIR_OFF;
      else if (des == last_r || pz_r == '0) cur_nxt = des;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_r <= DIR_OFF;
      last_r <= DIR_OFF;
      pz_r <= '0;
      pole_s_pos <= 1'b0;
      pole_o_pos <= 1'b0;
      load_on <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
      if (cur_r != DIR_OFF && cur_nxt == DIR_OFF) begin
        last_r <= cur_r;
        pz_r <= 9'(PAUSE_MS);
      end else if (ms_tick && pz_r != '0) begin
        pz_r <= pz_r - 1'b1;
      end
      pole_s_pos <= cur_nxt == DIR_OPEN;
      pole_o_pos <= cur_nxt == DIR_CLOSE;
      load_on <= ld;
    end
  end

  // Indicators
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarm_ind <= 1'b0;
      vent_ind <= 1'b0;
    end else begin
      alarm_ind <= a_req;
      vent_ind <= vent_on_r;
    end
  end

  // Register read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        REG_CTRL: rdata <= {24'h000000, ctrl_r};
        REG_PRIO: rdata <= {23'h000000, prio_r};
        REG_GRP0: rdata <= 32'(grp_r[0]);
        REG_GRP1: rdata <= 32'(grp_r[1]);
        REG_GRP2: rdata <= 32'(grp_r[2]);
        REG_ADLY: rdata <= {16'h0000, adly_r};
        REG_VDLY: rdata <= {16'h0000, vdly_r};
        REG_GAP: rdata <= {16'h0000, gap_r};
        REG_ACLS: rdata <= {14'h0000, acls_r};
        REG_TWAIT: rdata <= {16'h0000, twait_r};
        REG_BMODE: rdata <= {20'h00000, bmode_r};
        REG_STAT: rdata <= {15'h0000, wind_force, load_on, tl_r != '0, rt_n_r, rt_st,
                            s_ana, s_mains, cur_r, vent_dir_r == DIR_CLOSE, vent_on_r,
                            a_go, a_req};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule : smoke_vent_motor_relay_control

// ==== dv/vent_relay_monitor.sv ====
`timescale 1ns/100ps
module vent_relay_monitor #(
  parameter int NSI = 4,
  parameter int MS_CYC = vent_relay_pkg::MS_CYC_DEF
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [vent_relay_pkg::ADDR_W-1:0] addr, // Address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic mains_ok, // Mains
  input wire logic analog_ok, // Loop current
  input wire logic pole_s_pos, // OPEN drive
  input wire logic pole_o_pos, // CLOSE drive
  input wire logic load_on, // Load relays
  input wire logic alarm_ind, // Alarm
  input wire logic vent_ind // Vent command
);
  import vent_relay_pkg::*;
  localparam int PAUSE_MIN = (PAUSE_MS - 1) * MS_CYC;
  localparam int OPEN_WIN = PAUSE_MS * MS_CYC + 20;
  logic [7:0] ctrl_r;
  logic [8:0] prio_r;
  logic [31:0] adly_r;
  logic [1:0] last_r;
  int idle_r;
  // Shadow of settings that gate the checks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      prio_r <= PRIO_RST;
      adly_r <= 32'h0;
    end else begin
      if (wr_en && addr == REG_CTRL) ctrl_r <= wdata[7:0];
      if (wr_en && addr == REG_PRIO) prio_r <= wdata[8:0];
      if (wr_en && addr == REG_ADLY) adly_r <= wdata;
    end
  end
  // Last drive direction and idle time since
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_r <= 2'h0;
      idle_r <= 0;
    end else if (pole_s_pos || pole_o_pos) begin
      last_r <= {pole_o_pos, pole_s_pos};
      idle_r <= 0;
    end else begin
      idle_r <= idle_r + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  poles_excl_a: assert property (!(pole_s_pos && pole_o_pos))
    else $error("Both poles driven");
  reverse_pause_a: assert property (
    (pole_s_pos || pole_o_pos) && last_r != 2'h0 && last_r != {pole_o_pos, pole_s_pos}
    |-> idle_r >= PAUSE_MIN) else $error("Reversal too soon");
  mains_refuse_a: assert property ((!mains_ok) [*6] |=> !$rose(vent_ind))
    else $error("Vent taken on battery");
  battery_idle_a: assert property (
    (!mains_ok && !alarm_ind && !vent_ind) [*6] |-> !load_on) else $error("Relays held");
  drive_load_a: assert property ((pole_s_pos || pole_o_pos) [*2] |-> load_on)
    else $error("Drive without relays");
  dep_block_a: assert property (
    (ctrl_r[2] && alarm_ind && !analog_ok) [*5] |-> !pole_s_pos && !pole_o_pos)
    else $error("Drive without loop current");
  alarm_delay_a: assert property (
    $rose(alarm_ind) && adly_r != 32'h0 |-> ##2 (!pole_s_pos && !pole_o_pos) [*6])
    else $error("Alarm moved before delay");
  alarm_open_a: assert property (
    $rose(alarm_ind) && prio_r == PRIO_RST && adly_r == 32'h0 && ctrl_r == CTRL_RST
    |-> ##[0:OPEN_WIN] pole_s_pos) else $error("Alarm did not open");
  reverse_c: cover property ($rose(pole_o_pos) && last_r == 2'h1);
  delay_c: cover property ($rose(alarm_ind) && adly_r != 32'h0);
  battery_c: cover property (!mains_ok && load_on);
endmodule : vent_relay_monitor
bind smoke_vent_motor_relay_control vent_relay_monitor #(.NSI(NSI), .MS_CYC(MS_CYC)) mon (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .mains_ok(mains_ok), .analog_ok(analog_ok), .pole_s_pos(pole_s_pos),
  .pole_o_pos(pole_o_pos), .load_on(load_on), .alarm_ind(alarm_ind), .vent_ind(vent_ind));

// ==== dv/vent_actuator_model.sv ====
`timescale 1ns/100ps
module vent_actuator_model (
  input wire logic ref_clk, // Clock
  input wire logic pole_s_pos, // S plus
  input wire logic pole_o_pos, // O plus
  output int pos, // Stroke in drive cycles
  output int shorts // Cycles with both poles on
);
  initial begin
    pos = 0;
    shorts = 0;
  end
  always @(posedge ref_clk) begin
    if (pole_s_pos && pole_o_pos) begin
      shorts <= shorts + 1;
    end else if (pole_s_pos) begin
      pos <= pos + 1;
    end else if (pole_o_pos) begin
      pos <= pos - 1;
    end
  end
endmodule : vent_actuator_model

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
  import vent_relay_pkg::*;
  localparam int NSI = 4;
  localparam int MC = 1;
  localparam int PW = PAUSE_MS * MC + 50;
  logic ref_clk, rst, wr_en, rd_en, mains_ok, analog_ok, wind_rain_signal, thermostat_in;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, rv, e, seed;
  logic [2:0][NSI-1:0] sensor_trig;
  logic [3:0] vent_button_inputs;
  logic pole_s_pos, pole_o_pos, load_on, alarm_ind, vent_ind;
  int pos, shorts, num_errors, comparisons, m, p0;
  logic [7:0] ra[6] = '{REG_CTRL, REG_PRIO, REG_GRP0, REG_TWAIT, REG_BMODE, 8'h30};
  logic [31:0] rx[6] = '{32'h0, 32'h24, 32'hf, 32'ha, 32'h0, 32'h0};
  // {active lines, priority word}
  logic [11:0] pc[4] = '{{3'h6, 9'h024}, {3'h6, 9'h106}, {3'h4, 9'h0b1}, {3'h2, 9'h0b1}};
  // {stays on after release, long hold, mode}
  logic [4:0] bm[5] = '{5'h08, 5'h11, 5'h1a, 5'h1b, 5'h04};
  smoke_vent_motor_relay_control #(.NSI(NSI), .MS_CYC(MC)) dut (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .sensor_trig(sensor_trig), .mains_ok(mains_ok), .analog_ok(analog_ok),
    .wind_rain_signal(wind_rain_signal), .vent_button_inputs(vent_button_inputs),
    .thermostat_in(thermostat_in), .pole_s_pos(pole_s_pos), .pole_o_pos(pole_o_pos),
    .load_on(load_on), .alarm_ind(alarm_ind), .vent_ind(vent_ind));
  vent_actuator_model act (.ref_clk(ref_clk), .pole_s_pos(pole_s_pos),
    .pole_o_pos(pole_o_pos), .pos(pos), .shorts(shorts));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // First listed active line decides; inverted lines close
  function automatic logic [31:0] exp_dir(logic [8:0] p, logic [2:0] act);
    int q[$];
    for (int i = 0; i < 3; i++) begin
      if (p[2*i+:2] != 2'h3) q.push_back(p[2*i+:2]);
    end
    foreach (q[i]) begin
      if (act[q[i]]) return p[6+q[i]] ? 32'h2 : 32'h1;
    end
    return 32'h0;
  endfunction : exp_dir
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    rv = rdata;
  endtask : rd
  // Drive direction seen mid-cycle, then back on a rising edge
  task automatic look(int n, logic [31:0] d, string msg);
    cyc(n);
    @(negedge ref_clk);
    chk({30'h0, pole_o_pos, pole_s_pos}, d, msg);
    @(posedge ref_clk);
  endtask : look
  task automatic press(int b, int n);
    vent_button_inputs[b] <= 1'b1;
    cyc(n);
    vent_button_inputs[b] <= 1'b0;
  endtask : press
  task automatic do_reset();
    rst <= 1'b1;
    cyc(20);
    rst <= 1'b0;
    cyc(5);
  endtask : do_reset
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    cyc(90000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    num_errors = 0;
    comparisons = 0;
    seed = 32'h34a6efbe;
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
    sensor_trig = '0;
    mains_ok = 1'b1;
    analog_ok = 1'b1;
    wind_rain_signal = 1'b0;
    thermostat_in = 1'b0;
    vent_button_inputs = '0;
    cyc(19);
    @(negedge ref_clk);
    chk({load_on, alarm_ind, vent_ind, pole_o_pos, pole_s_pos}, 0, "reset outputs");
    @(posedge ref_clk);
    rst <= 1'b0;
    look(10, 0, "idle");
    chk(load_on, 1, "relays on mains");
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rv, rx[i], "register reset");
    end
    m = xs() % NSI;
    foreach (pc[i]) begin
      wr(REG_PRIO, {23'h0, pc[i][8:0]});
      for (int l = 0; l < 3; l++) sensor_trig[l][m] <= pc[i][9+l];
      e = exp_dir(pc[i][8:0], pc[i][11:9]);
      look(PW, e, "priority drive");
      chk(alarm_ind, e != 0, "alarm shown");
      sensor_trig <= '0;
      look(PW, 0, "alarm gone");
    end
    wr(REG_PRIO, 32'h24);
    wr(REG_GRP1, ~(32'h1 << m) & 32'hf);
    for (int x = 0; x < 2; x++) begin
      wr(REG_CTRL, {30'h0, x[0], 1'b0});
      sensor_trig[1][m] <= 1'b1;
      look(20, x ? 0 : 1, "sensor group");
      sensor_trig[1][m] <= 1'b0;
      cyc(20);
    end
    wr(REG_CTRL, 0);
    wr(REG_ADLY, 1);
    sensor_trig[0][m] <= 1'b1;
    look(20, 0, "alarm delay hold");
    chk(alarm_ind, 1, "alarm shown early");
    look(MS_PER_S * MC, 1, "alarm delay over");
    sensor_trig[0][m] <= 1'b0;
    wr(REG_ADLY, 0);
    wr(REG_CTRL, 32'h4);
    analog_ok <= 1'b0;
    sensor_trig[0][m] <= 1'b1;
    look(20, 0, "no loop current");
    analog_ok <= 1'b1;
    look(20, 1, "loop current");
    sensor_trig[0][m] <= 1'b0;
    wr(REG_CTRL, 0);
    mains_ok <= 1'b0;
    look(20, 0, "battery idle");
    chk(load_on, 0, "relays off on battery");
    press(0, 10);
    look(20, 0, "vent on battery");
    chk(vent_ind, 0, "vent refused");
    sensor_trig[0][m] <= 1'b1;
    look(40, 1, "alarm on battery");
    chk(load_on, 1, "relays back for alarm");
    sensor_trig[0][m] <= 1'b0;
    mains_ok <= 1'b1;
    cyc(20);
    press(0, 10);
    look(10, 1, "brief press latch");
    chk(vent_ind, 1, "vent shown");
    press(0, 10);
    look(10, 0, "tip stop");
    press(0, 10);
    wr(REG_PRIO, 32'h64);
    sensor_trig[0][m] <= 1'b1;
    look(PW, 2, "alarm over vent");
    sensor_trig[0][m] <= 1'b0;
    foreach (bm[i]) begin
      do_reset();
      wr(REG_BMODE, {29'h0, bm[i][2:0]});
      vent_button_inputs[0] <= 1'b1;
      look(bm[i][3] ? DM_HOLD_MS * MC + 200 : 20, 1, "button held");
      vent_button_inputs[0] <= 1'b0;
      look(20, {31'h0, bm[i][4]}, "button released");
    end
    do_reset();
    wr(REG_CTRL, 32'h10);
    wr(REG_GAP, 1);
    p0 = pos;
    press(0, 10);
    look(MS_PER_S * MC + 200, 0, "gap open end");
    chk(pos - p0 > MS_PER_S * MC - 10 && pos - p0 < MS_PER_S * MC + 10, 1, "gap stroke");
    press(1, 10);
    press(0, 10);
    look(600, 2, "open refused in gap close");
    look(1500, 0, "gap close end");
    wr(REG_CTRL, 32'h8);
    wind_rain_signal <= 1'b1;
    look(PW, 2, "wind close");
    chk(shorts, 0, "poles never together");
    report_and_stop();
  end
endmodule : tb
